// *** logic/cpp_pkg.sv ***
// Shared constants and types of the configuration port pin control block
package cpp_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS      = 4;     // Core clock period, 250 MHz
	localparam int T_PRGM_NS   = 55;    // Least restart pulse that is accepted
	localparam int T_PRGMJ_NS  = 25;    // Longest restart pulse that is rejected
	localparam int T_INITL_US  = 105;   // Longest init-low time after a restart
	localparam int T_CSSPI_NS  = 100;   // Least init-high to flash select low
	localparam int T_MCLK_NS   = 750;   // Least init-high to first master clock edge
	// Least times round up, longest times round down
	localparam int PRGM_CYC    = (T_PRGM_NS + CLK_NS - 1) / CLK_NS;
	localparam int INITL_CYC   = (T_INITL_US * 1000) / CLK_NS;
	localparam int CSSPI_CYC   = (T_CSSPI_NS + CLK_NS - 1) / CLK_NS;
	localparam int MCLK_CYC    = (T_MCLK_NS + CLK_NS - 1) / CLK_NS;
	localparam int MCLK_HALF   = 4;     // Core cycles per master clock half period
	localparam int WAKE_CYC    = 8;     // Start-up cycles with completion released

	// ----------------------------------------------------------------
	// Data path and flash commands
	// ----------------------------------------------------------------
	localparam int        BYTE_W       = 8;
	localparam int        IMAGE_BYTES  = 64;     // Bytes in one configuration image
	localparam int        CMD_BITS     = 32;     // Read command plus address
	localparam int        CMD_BITS_ALT = 40;     // Fast read plus address and dummy
	localparam int        SHO_W        = 40;
	localparam logic [7:0] CMD_READ    = 8'h03;
	localparam logic [7:0] CMD_FREAD   = 8'h0B;
	localparam logic [23:0] FLASH_BASE = 24'h000000;

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_CODE_SLAVE_SPI  = 3'h0;
	localparam logic [2:0] MODE_CODE_MASTER_SPI = 3'h1;
	localparam logic [2:0] MODE_CODE_MASTER_ALT = 3'h2;
	localparam logic [2:0] MODE_CODE_I2C_SLAVE  = 3'h3;
	localparam logic [2:0] MODE_CODE_I2C_MASTER = 3'h4;

	typedef enum logic [2:0] {
		MODE_SLAVE_SPI,
		MODE_MASTER_SPI,
		MODE_MASTER_SPI_VARIANT,
		MODE_I2C_SLAVE,
		MODE_I2C_MASTER
	} cpp_mode_t;

	typedef enum logic [2:0] {
		ST_CLEAR,
		ST_WAIT_INIT,
		ST_LOAD,
		ST_WAKE,
		ST_USER
	} cpp_state_t;

endpackage

// *** logic/cpp_config_port.sv ***
// Configuration port pin control: status pins, restart, SPI and I2C pin roles
//
// Function
// - Open-drain init pin signals ready for data
// - Init pin pulled up while configuring or kept
// - Open-drain done pin signals load finished
// - Done pin pulled up while configuring or kept
// - Master SPI: device drives configuration clock out
// - Master SPI: device drives low flash select
// - Data pin A: slave input, master output
// - Data pin B: slave output, master input
// - I2C clock: slave input, master driven
// - I2C data: slave input, master driven
`timescale 1ns/1ps

module cpp_config_port #(
	parameter int INIT_LOW_CYC = cpp_pkg::INITL_CYC,
	parameter int DATA_W       = cpp_pkg::BYTE_W,
	parameter int IMG_BYTES    = cpp_pkg::IMAGE_BYTES
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              slave_config_clock,
	input  wire logic              config_restart_n,
	input  wire logic [2:0]        mode_pins,
	input  wire logic              keep_status_pins,
	input  wire logic              init_ready_n_i,
	output logic                   init_ready_n_o,
	output logic                   init_ready_n_oe,
	output logic                   init_pullup_en,
	input  wire logic              config_done_i,
	output logic                   config_done_o,
	output logic                   config_done_oe,
	output logic                   done_pullup_en,
	output logic                   slave_config_clock_o,
	output logic                   slave_config_clock_oe,
	input  wire logic              slave_select_n,
	output logic                   flash_select_n,
	input  wire logic              serial_data_a_i,
	output logic                   serial_data_a_o,
	output logic                   serial_data_a_oe,
	input  wire logic              serial_data_b_i,
	output logic                   serial_data_b_o,
	output logic                   serial_data_b_oe,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	output logic                   user_io_en,
	output logic [DATA_W-1:0]      cfg_data,
	output logic                   cfg_valid,
	input  wire logic              cfg_ready,
	output logic                   cfg_overrun
);
	import cpp_pkg::*;

	// ----------------------------------------------------------------
	// Widths and state records
	// ----------------------------------------------------------------
	localparam int TMAX = (INIT_LOW_CYC > MCLK_CYC) ? INIT_LOW_CYC : MCLK_CYC;
	localparam int TW   = $clog2(TMAX + WAKE_CYC + 2);
	localparam int NW   = $clog2(IMG_BYTES + 1);

	typedef struct packed {
		cpp_state_t          st;
		cpp_mode_t           mode;
		logic [TW-1:0]       tmr;
		logic [4:0]          rst_cnt;
		logic [2:0]          rs_s;
		logic                rs_f;
		logic [2:0]          ir_s;
		logic                ir_f;
		logic [2:0]          dn_s;
		logic                dn_f;
		logic [2:0]          sb_s;
		logic                sb_f;
		logic [2:0]          sl_s;
		logic                sl_f;
		logic [2:0]          tg_s;
		logic                tg_f;
		logic [2:0]          md_s0;
		logic [2:0]          md_s1;
		logic [2:0]          md_s2;
		logic [2:0]          md_f;
		logic                init_oe;
		logic                done_oe;
		logic                pull_init;
		logic                pull_done;
		logic                user_io;
		logic                busy;
		logic                fsel_n;
		logic                sda_a_oe;
		logic                sdb_oe;
		logic                slave_config_clock_oe;
		logic                scl_oe;
		logic                sda_oe;
		logic                go;
		logic                mclk;
		logic [3:0]          div;
		logic                rd;
		logic [5:0]          bitc;
		logic [SHO_W-1:0]    sh_out;
		logic [7:0]          sh_in;
		logic [NW-1:0]       nbytes;
		logic                out_v;
		logic [DATA_W-1:0]   out_d;
		logic                sp_v;
		logic [DATA_W-1:0]   sp_d;
		logic                ovr;
	} core_t;

	typedef struct packed {
		logic [7:0] sh;
		logic [7:0] hold;
		logic       tog;
		logic [1:0] bz;
		logic       sdo;
	} lnk_t;

	core_t q;
	core_t d;
	lnk_t  l_q;
	lnk_t  l_d;
	logic [2:0] lbit_q;
	logic       lnk_clr_n;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A pin change counts once the second and third stages agree
	function automatic logic filt(input logic [2:0] s, input logic f);
		return (s[1] == s[2]) ? s[2] : f;
	endfunction

	function automatic cpp_mode_t mode_of(input logic [2:0] p);
		case (p)
			MODE_CODE_MASTER_SPI: return MODE_MASTER_SPI;
			MODE_CODE_MASTER_ALT: return MODE_MASTER_SPI_VARIANT;
			MODE_CODE_I2C_SLAVE:  return MODE_I2C_SLAVE;
			MODE_CODE_I2C_MASTER: return MODE_I2C_MASTER;
			default:              return MODE_SLAVE_SPI;
		endcase
	endfunction

	function automatic logic is_mspi(input cpp_mode_t m);
		return (m == MODE_MASTER_SPI) || (m == MODE_MASTER_SPI_VARIANT);
	endfunction

	function automatic logic [5:0] cmd_len(input cpp_mode_t m);
		return (m == MODE_MASTER_SPI_VARIANT) ? 6'(CMD_BITS_ALT) : 6'(CMD_BITS);
	endfunction

	// ----------------------------------------------------------------
	// Link domain: slave SPI receive on the host's clock
	// ----------------------------------------------------------------
	// Bit position clears with the select, since the host clock stops between frames
	assign lnk_clr_n = rstn & ~slave_select_n;

	always_ff @(posedge slave_config_clock or negedge lnk_clr_n) begin
		if (!lnk_clr_n) begin
			lbit_q <= 3'h0;
		end else begin
			lbit_q <= lbit_q + 3'h1;
		end
	end

	// Shift bits in from pin A; each full byte is held and flagged by a toggle
	always_comb begin
		l_d = l_q;
		l_d.sh = {l_q.sh[6:0], serial_data_a_i};
		if (lbit_q == 3'h7) begin
			l_d.hold = {l_q.sh[6:0], serial_data_a_i};
			l_d.tog  = ~l_q.tog;
		end
		l_d.bz  = {l_q.bz[0], q.busy};
		l_d.sdo = l_q.bz[1];
	end

	always_ff @(posedge slave_config_clock or negedge rstn) begin
		if (!rstn) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// ----------------------------------------------------------------
	// Core domain
	// ----------------------------------------------------------------
	// Sequencer, master clock engine and the two-entry buffer
	always_comb begin
		logic             pop;
		logic             push;
		logic [DATA_W-1:0] push_d;
		logic             lnk_evt;
		logic             restart;
		logic             can_rise;
		pop      = q.out_v & cfg_ready;
		push     = 1'b0;
		push_d   = '0;
		lnk_evt  = 1'b0;
		restart  = 1'b0;
		can_rise = 1'b0;
		d = q;

		// Pin synchronisers
		d.rs_s = {q.rs_s[1:0], config_restart_n};
		d.rs_f = filt(q.rs_s, q.rs_f);
		d.ir_s = {q.ir_s[1:0], init_ready_n_i};
		d.ir_f = filt(q.ir_s, q.ir_f);
		d.dn_s = {q.dn_s[1:0], config_done_i};
		d.dn_f = filt(q.dn_s, q.dn_f);
		d.sb_s = {q.sb_s[1:0], serial_data_b_i};
		d.sb_f = filt(q.sb_s, q.sb_f);
		d.sl_s = {q.sl_s[1:0], slave_select_n};
		d.sl_f = filt(q.sl_s, q.sl_f);
		d.tg_s = {q.tg_s[1:0], l_q.tog};
		d.tg_f = filt(q.tg_s, q.tg_f);
		lnk_evt = (q.tg_s[1] == q.tg_s[2]) && (q.tg_s[2] != q.tg_f);
		d.md_s0 = mode_pins;
		d.md_s1 = q.md_s0;
		d.md_s2 = q.md_s1;
		if (q.md_s1 == q.md_s2) begin
			d.md_f = q.md_s2;
		end

		// Restart filter: short glitches never reach the count
		if (q.rs_f) begin
			d.rst_cnt = 5'h00;
		end else if (q.rst_cnt != 5'(PRGM_CYC)) begin
			d.rst_cnt = q.rst_cnt + 5'h01;
		end
		restart = (q.rst_cnt == 5'(PRGM_CYC));

		// Master clock edge ready; a new byte waits for buffer room
		can_rise = !(q.rd && (q.bitc[2:0] == 3'h0) && q.sp_v);

		unique case (q.st)
			ST_CLEAR: begin
				d.init_oe = 1'b1;
				d.done_oe = 1'b1;
				d.user_io = 1'b0;
				d.mode    = mode_of(q.md_f);
				if (q.tmr != '0) begin
					d.tmr = q.tmr - TW'(1);
				end else begin
					d.st = ST_WAIT_INIT;
				end
			end
			ST_WAIT_INIT: begin
				// Released init pin shows readiness; wait for the wired level
				d.init_oe = 1'b0;
				if (q.ir_f) begin
					d.st     = ST_LOAD;
					d.tmr    = '0;
					d.nbytes = '0;
					d.rd     = 1'b0;
					d.bitc   = 6'h00;
					d.go     = 1'b0;
					d.mclk   = 1'b0;
					d.div    = 4'(MCLK_HALF - 1);
				end
			end
			ST_LOAD: begin
				if (q.tmr != {TW{1'b1}}) begin
					d.tmr = q.tmr + TW'(1);
				end
				if (is_mspi(q.mode) && (q.tmr == TW'(CSSPI_CYC))) begin
					d.fsel_n = 1'b0;
					d.sh_out = {(q.mode == MODE_MASTER_SPI_VARIANT) ? CMD_FREAD : CMD_READ,
						FLASH_BASE, 8'h00};
				end
				if ((q.mode == MODE_I2C_MASTER) && (q.tmr == TW'(CSSPI_CYC))) begin
					d.sda_oe = 1'b1;
				end
				if ((is_mspi(q.mode) || (q.mode == MODE_I2C_MASTER))
					&& (q.tmr == TW'(MCLK_CYC))) begin
					d.go = 1'b1;
				end
				// Clock engine: data shifts after the falling edge, samples before it
				if (q.go) begin
					if (q.div != 4'h0) begin
						d.div = q.div - 4'h1;
					end else if (!q.mclk) begin
						if (can_rise) begin
							d.mclk = 1'b1;
							d.div  = 4'(MCLK_HALF - 1);
						end
					end else begin
						d.mclk  = 1'b0;
						d.div   = 4'(MCLK_HALF - 1);
						d.sh_in = {q.sh_in[6:0], q.sb_f};
						if (!q.rd) begin
							d.sh_out = {q.sh_out[SHO_W-2:0], 1'b0};
							if (q.bitc == cmd_len(q.mode) - 6'h01) begin
								d.rd   = 1'b1;
								d.bitc = 6'h00;
							end else begin
								d.bitc = q.bitc + 6'h01;
							end
						end else begin
							d.bitc = {3'h0, q.bitc[2:0] + 3'h1};
							if (q.bitc[2:0] == 3'h7) begin
								push   = is_mspi(q.mode);
								push_d = DATA_W'({q.sh_in[6:0], q.sb_f});
							end
						end
					end
				end
				// Slave bytes arrive through the toggle crossing
				if ((q.mode == MODE_SLAVE_SPI) && lnk_evt) begin
					push   = 1'b1;
					push_d = DATA_W'(l_q.hold);
				end
				if (push && (q.nbytes == NW'(IMG_BYTES - 1))) begin
					d.st     = ST_WAKE;
					d.tmr    = '0;
					d.done_oe = 1'b0;
					d.fsel_n = 1'b1;
					d.go     = 1'b0;
					d.mclk   = 1'b0;
					d.sda_oe = 1'b0;
				end
				if (push) begin
					d.nbytes = q.nbytes + NW'(1);
				end
			end
			ST_WAKE: begin
				// Start-up runs with completion released; others may still hold it low
				d.tmr = q.tmr + TW'(1);
				if ((q.tmr >= TW'(WAKE_CYC)) && q.dn_f) begin
					d.st      = ST_USER;
					d.user_io = 1'b1;
				end
			end
			ST_USER: begin
				d.user_io = 1'b1;
			end
		endcase

		// Accepted restart pulse overrides everything and reloads
		if (restart) begin
			d.st      = ST_CLEAR;
			d.tmr     = TW'(INIT_LOW_CYC);
			d.init_oe = 1'b1;
			d.done_oe = 1'b1;
			d.user_io = 1'b0;
			d.fsel_n  = 1'b1;
			d.go      = 1'b0;
			d.mclk    = 1'b0;
			d.sda_oe  = 1'b0;
			push      = 1'b0;
		end

		// Pin roles follow the latched mode
		d.busy      = (d.st != ST_USER);
		d.pull_init = d.busy | keep_status_pins;
		d.pull_done = d.busy | keep_status_pins;
		d.slave_config_clock_oe   = is_mspi(d.mode) && (d.st == ST_LOAD);
		d.sda_a_oe  = is_mspi(d.mode) && !d.fsel_n;
		d.sdb_oe    = (d.mode == MODE_SLAVE_SPI) && !q.sl_f && d.busy;
		d.scl_oe    = (d.mode == MODE_I2C_MASTER) && d.go && !d.mclk;

		// Two-entry buffer; the master engine stalls on a full spare entry
		if (pop) begin
			d.out_v = 1'b0;
			if (q.sp_v) begin
				d.out_d = q.sp_d;
				d.out_v = 1'b1;
				d.sp_v  = 1'b0;
			end
		end
		if (push) begin
			if (q.sp_v) begin
				d.ovr = 1'b1;
			end else if (!d.out_v) begin
				d.out_d = push_d;
				d.out_v = 1'b1;
			end else begin
				d.sp_d = push_d;
				d.sp_v = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q           <= '0;
			q.st        <= ST_CLEAR;
			q.tmr       <= TW'(INIT_LOW_CYC);
			q.rs_s      <= 3'h7;
			q.rs_f      <= 1'b1;
			q.sl_s      <= 3'h7;
			q.sl_f      <= 1'b1;
			q.init_oe   <= 1'b1;
			q.done_oe   <= 1'b1;
			q.pull_init <= 1'b1;
			q.pull_done <= 1'b1;
			q.busy      <= 1'b1;
			q.fsel_n    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open-drain pins only ever pull low
	assign init_ready_n_o   = 1'b0;
	assign init_ready_n_oe  = q.init_oe;
	assign init_pullup_en   = q.pull_init;
	assign config_done_o    = 1'b0;
	assign config_done_oe   = q.done_oe;
	assign done_pullup_en   = q.pull_done;
	assign slave_config_clock_o           = q.mclk;
	assign slave_config_clock_oe          = q.slave_config_clock_oe;
	assign flash_select_n   = q.fsel_n;
	assign serial_data_a_o  = q.sh_out[SHO_W-1];
	assign serial_data_a_oe = q.sda_a_oe;
	assign serial_data_b_o  = l_q.sdo;
	assign serial_data_b_oe = q.sdb_oe;
	assign scl_o            = 1'b0;
	assign scl_oe           = q.scl_oe;
	assign sda_o            = 1'b0;
	assign sda_oe           = q.sda_oe;
	assign user_io_en       = q.user_io;
	assign cfg_data         = q.out_d;
	assign cfg_valid        = q.out_v;
	assign cfg_overrun      = q.ovr;

endmodule

// *** tb/cpp_config_port_asserts.sv ***
// Checker for the configuration port pin roles and sequence
`timescale 1ns/1ps

module cpp_config_port_asserts #(
	parameter int DATA_W = 8
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              config_restart_n,
	input wire logic              init_ready_n_oe,
	input wire logic              init_pullup_en,
	input wire logic              config_done_oe,
	input wire logic              done_pullup_en,
	input wire logic              slave_config_clock_o,
	input wire logic              slave_config_clock_oe,
	input wire logic              flash_select_n,
	input wire logic              serial_data_a_oe,
	input wire logic              serial_data_b_oe,
	input wire logic              scl_oe,
	input wire logic              sda_oe,
	input wire logic              user_io_en,
	input wire logic [DATA_W-1:0] cfg_data,
	input wire logic              cfg_valid,
	input wire logic              cfg_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----
	// Restart pin sequences
	// ----
	// Repetitions stay short; three chained spans cover the answer time
	sequence low8;
		(!config_restart_n) [*8];
	endsequence
	sequence high8;
		config_restart_n [*8];
	endsequence

	a_restart_clears: assert property ($fell(config_restart_n) ##0 low8 ##1 low8 ##1 low8
		|-> init_ready_n_oe && config_done_oe && !user_io_en)
		else $error("restart did not clear status pins");
	a_short_ignored: assert property (user_io_en && $fell(config_restart_n)
		##0 (!config_restart_n) [*5] ##1 high8 ##1 high8 |-> user_io_en)
		else $error("short restart pulse was taken");
	a_init_pull_cfg: assert property (!user_io_en |-> init_pullup_en)
		else $error("init pull-up off while configuring");
	a_done_pull_cfg: assert property (!user_io_en |-> done_pullup_en)
		else $error("done pull-up off while configuring");
	a_fsel_delay: assert property ($fell(flash_select_n) |-> !$past(init_ready_n_oe, 24))
		else $error("flash select too soon after init release");
	a_clk_selected: assert property (slave_config_clock_oe && $rose(slave_config_clock_o) |-> !flash_select_n)
		else $error("master clock runs with flash deselected");
	a_flash_drive: assert property (!flash_select_n |-> serial_data_a_oe)
		else $error("data pin A not driven while flash selected");
	a_data_dirs: assert property (serial_data_a_oe |-> !serial_data_b_oe)
		else $error("both serial data pins driven");
	a_i2c_pins: assert property ((scl_oe || sda_oe) |-> !slave_config_clock_oe && flash_select_n)
		else $error("I2C pin driven in SPI mode");
	a_done_first: assert property ($rose(user_io_en)
		|-> !config_done_oe && !init_ready_n_oe && !$past(config_done_oe, 6))
		else $error("user mode without done released");
	a_buf_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
		else $error("buffer head changed while stalled");
endmodule

bind cpp_config_port cpp_config_port_asserts #(.DATA_W(DATA_W)) u_chk (
	.clk, .rstn, .config_restart_n, .init_ready_n_oe, .init_pullup_en,
	.config_done_oe, .done_pullup_en, .slave_config_clock_o, .slave_config_clock_oe, .flash_select_n,
	.serial_data_a_oe, .serial_data_b_oe, .scl_oe, .sda_oe, .user_io_en,
	.cfg_data, .cfg_valid, .cfg_ready
);

// *** tb/cpp_flash_model.sv ***
// Behavioural serial flash at the master side of the configuration port
`timescale 1ns/1ps

module cpp_flash_model (
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic mosi,
	output logic      miso
);
	logic [39:0] cmd_q;
	logic [7:0]  op;
	logic [7:0]  img;
	logic        out_q;
	logic        drive;
	int          nbit;
	int          nout;

	// Command bits on rising edges; fast read carries address and dummy byte
	always @(posedge sck) begin
		if (!cs_n && nbit < ((op == 8'h0B) ? 40 : 32)) begin
			cmd_q = {cmd_q[38:0], mosi};
			nbit++;
			if (nbit == 8)
				op = cmd_q[7:0];
		end
	end

	// Image bits leave on falling edges, so they are settled at the next high phase
	always @(negedge sck) begin
		if (!cs_n && nbit == ((op == 8'h0B) ? 40 : 32)) begin
			img = 8'hC3 + 8'(nout / 8);
			out_q = img[7 - nout % 8];
			nout++;
			drive = 1'h1;
		end
	end

	// Deselect ends a transfer
	always @(posedge cs_n or negedge drive) begin
		nbit = 0;
		nout = 0;
		op = 8'h00;
	end
	always @(posedge cs_n)
		drive = 1'h0;

	initial begin
		drive = 1'h0;
		out_q = 1'h0;
		op = 8'h00;
	end
	// A released line shows the inverse of its last bit, never a stale copy
	assign miso = (drive && !cs_n) ? out_q : ~out_q;
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the configuration port pin control block
`timescale 1ns/1ps

module tb;
	import cpp_pkg::*;
	// ----
	// Signals and instances
	// ----
	localparam int ILOW = 50; // Short init-low count keeps the run brief
	localparam int NIMG = 4;
	logic       clk, rstn, slave_config_clock, config_restart_n, keep_status_pins;
	logic       slave_select_n, cfg_ready, host_a, miso, cfg_valid, cfg_overrun;
	logic [2:0] mode_pins;
	logic       init_ready_n_o, init_ready_n_oe, init_pullup_en, config_done_o;
	logic       config_done_oe, done_pullup_en, slave_config_clock_o, slave_config_clock_oe, flash_select_n;
	logic       serial_data_a_o, serial_data_a_oe, serial_data_b_o, serial_data_b_oe;
	logic       scl_o, scl_oe, sda_o, sda_oe, user_io_en;
	logic [7:0] cfg_data;
	logic [7:0] got_q[$];
	int         num_errors, total_checks;
	logic [5:0] row_mode [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07};
	logic [5:0] row_exp  [6] = '{6'h14, 6'h28, 6'h28, 6'h10, 6'h12, 6'h14};
	logic [5:0] row_care [6] = '{6'h3F, 6'h3F, 6'h3F, 6'h33, 6'h32, 6'h3F};
	// Open-drain pins rest on pull-ups; shared pins resolve by enable
	wire init_ready_n_i  = init_ready_n_oe ? init_ready_n_o : 1'h1;
	wire config_done_i   = config_done_oe ? config_done_o : 1'h1;
	wire serial_data_a_i = serial_data_a_oe ? serial_data_a_o : host_a;
	wire serial_data_b_i = serial_data_b_oe ? serial_data_b_o : miso;
	wire scl_i           = scl_oe ? scl_o : 1'h1;
	wire sda_i           = sda_oe ? sda_o : 1'h1;
	wire [4:0] stat  = {init_ready_n_oe, config_done_oe, init_pullup_en, done_pullup_en,
		flash_select_n};
	wire [5:0] roles = {slave_config_clock_oe, flash_select_n, serial_data_a_oe, serial_data_b_oe,
		sda_oe, scl_oe};

	cpp_config_port #(.INIT_LOW_CYC(ILOW), .IMG_BYTES(NIMG)) DUT (
		.clk, .rstn, .slave_config_clock, .config_restart_n, .mode_pins,
		.keep_status_pins, .init_ready_n_i, .init_ready_n_o, .init_ready_n_oe,
		.init_pullup_en, .config_done_i, .config_done_o, .config_done_oe,
		.done_pullup_en, .slave_config_clock_o, .slave_config_clock_oe, .slave_select_n, .flash_select_n,
		.serial_data_a_i, .serial_data_a_o, .serial_data_a_oe, .serial_data_b_i,
		.serial_data_b_o, .serial_data_b_oe, .scl_i, .scl_o, .scl_oe, .sda_i,
		.sda_o, .sda_oe, .user_io_en, .cfg_data, .cfg_valid, .cfg_ready, .cfg_overrun
	);
	cpp_flash_model u_flash (.cs_n(flash_select_n), .sck(slave_config_clock_o), .mosi(serial_data_a_o),
		.miso(miso));

	// Core clock, 4 ns
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// Words taken from the buffer
	always @(posedge clk) begin
		if (cfg_valid && cfg_ready)
			got_q.push_back(cfg_data);
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded wait; running out ends the run
	task automatic wait_hi(input string what, ref logic sig, input int lim);
		for (int n = 0; n < lim && sig !== 1'h1; n++)
			@(negedge clk);
		chk(what, 1'h1, sig);
		if (sig !== 1'h1)
			wrap_up();
	endtask

	// Mode is latched while the block clears, so it is set during reset
	task automatic do_reset(input logic [2:0] m);
		int n;
		rstn = 1'h0;
		mode_pins = m;
		got_q.delete();
		repeat (10) @(negedge clk);
		chk("reset_pins", 5'h1F, stat);
		chk("reset_user", 1'h0, user_io_en);
		rstn = 1'h1;
		for (n = 0; n < ILOW + 20 && init_ready_n_oe !== 1'h0; n++)
			@(negedge clk);
		chk("init_release", 1'h1, n >= ILOW && n <= ILOW + 4);
	endtask

	// Host frame off the core clock grid; the link clock stands still outside it
	task automatic host_frame(input logic [23:0] bytes);
		#7 slave_select_n = 1'h0;
		for (int i = 23; i >= 0; i--) begin
			host_a = bytes[i];
			#32 slave_config_clock = 1'h1;
			#32 slave_config_clock = 1'h0;
		end
		#20 slave_select_n = 1'h1;
		host_a = ~host_a;
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		rstn = 1'h0;
		slave_config_clock = 1'h0;
		config_restart_n = 1'h1;
		keep_status_pins = 1'h1;
		slave_select_n = 1'h0;
		cfg_ready = 1'h1;
		host_a = 1'h0;
		mode_pins = 3'h0;
		// Pin roles per mode; code 7 falls back to slave SPI
		for (int r = 0; r < 6; r++) begin
			do_reset(row_mode[r][2:0]);
			repeat (100) @(negedge clk);
			chk("pin_roles", row_exp[r] & row_care[r], roles & row_care[r]);
		end
		// Slave bytes against a stalled buffer: third is refused
		slave_select_n = 1'h1;
		cfg_ready = 1'h0;
		do_reset(3'h0);
		host_frame({8'h5A, 8'h81, 8'hFF});
		repeat (20) @(negedge clk);
		chk("overrun", 1'h1, cfg_overrun);
		chk("head", 8'h5A, cfg_data);
		chk("busy_out", 1'h1, serial_data_b_o);
		cfg_ready = 1'h1;
		repeat (6) @(negedge clk);
		cfg_ready = 1'h0;
		chk("drained", {8'h5A, 8'h81}, {got_q[0], got_q[1]});
		chk("drain_len", 2, got_q.size());
		chk("empty", 1'h0, cfg_valid);
		// Master loads in both command forms
		cfg_ready = 1'h1;
		do_reset(3'h1);
		wait_hi("user_mode", user_io_en, 5000);
		chk("read_cmd", {8'h03, 24'h000000}, u_flash.cmd_q[31:0]);
		for (int k = 0; k < NIMG; k++)
			chk("image", 8'hC3 + k, got_q[k]);
		chk("status_user", 2'h0, {config_done_oe, init_ready_n_oe});
		chk("pullups_kept", 2'h3, {init_pullup_en, done_pullup_en});
		chk("od_low", 4'h0, {init_ready_n_o, config_done_o, scl_o, sda_o});
		do_reset(3'h2);
		wait_hi("user_alt", user_io_en, 5000);
		chk("fast_cmd", {8'h0B, 24'h000000}, u_flash.cmd_q[39:8]);
		// Restart pulses: a short one is ignored, a long one clears and reloads
		config_restart_n = 1'h0;
		repeat (5) @(negedge clk);
		config_restart_n = 1'h1;
		repeat (30) @(negedge clk);
		chk("short_pulse", 1'h1, user_io_en);
		config_restart_n = 1'h0;
		repeat (24) @(negedge clk);
		chk("restart", 3'h6, {init_ready_n_oe, config_done_oe, user_io_en});
		config_restart_n = 1'h1;
		wait_hi("reload", user_io_en, 6000);
		wrap_up();
	end
endmodule
